// ==== htu_defines.vh ====
`ifndef HTU_DEFINES_VH
`define HTU_DEFINES_VH

// System clock rate in Hz.
`define HTU_CLK_HZ      20000000
// Slowest and fastest supported line rates in bit/s.
`define HTU_RATE_MIN    2400
`define HTU_RATE_MAX    921600
// Line rates picked by the three option straps; code 0 means the stored rate if valid and within the supported range, else auto detect.
`define HTU_RATE_1      9600
`define HTU_RATE_2      19200
`define HTU_RATE_3      38400
`define HTU_RATE_4      57600
`define HTU_RATE_5      115200
`define HTU_RATE_6      460800
`define HTU_RATE_7      921600
`define HTU_STRAP_AUTO  3'h0
// Clocks per bit until the straps have been latched, or in auto detect until a reference bit has been measured.
`define HTU_DIV_RESET   16'h00ae
// Width of a bit-time count in system clocks.
`define HTU_DIV_W       16
// Shortest start bit, in clocks, accepted as an auto-detect reference.
`define HTU_AUTO_MIN    16'h000b
// Parity mode encodings.
`define HTU_PAR_NONE    2'h0
`define HTU_PAR_ODD     2'h1
`define HTU_PAR_EVEN    2'h2
// Source of the active line rate.
`define HTU_SRC_STRAP   2'h0
`define HTU_SRC_STORE   2'h1
`define HTU_SRC_AUTO    2'h2
// Cycles the strap synchronisers need before the straps are latched.
`define HTU_SETTLE      2'h3
// Receive buffer depth.
`define HTU_BUF_DEPTH   2'h2

`endif

// ==== htu_uart.v ====
`timescale 1ns/10ps
`default_nettype none
`include "htu_defines.vh"

module htu_uart
(
   input  wire        clock,            // System clock, 20 MHz.
   input  wire        reset_n,          // Asynchronous reset, active low.
   input  wire        rx_pin,           // Serial receive line.
   output wire        tx_pin,           // Serial transmit line.
   output wire        rts_n_pin,        // Request to send, active low.
   input  wire        cts_n_pin,        // Clear to send, active low.
   input  wire        option_strap_a,   // Rate strap, bit 0.
   input  wire        option_strap_b,   // Rate strap, bit 1.
   input  wire        option_strap_c,   // Rate strap, bit 2.
   input  wire        store_valid,      // Stored rate is valid.
   input  wire [15:0] store_divisor,    // Stored clocks per bit.
   input  wire        flow_enable,      // RTS/CTS handshake on.
   input  wire [1:0]  parity_mode,      // None, odd or even.
   input  wire        two_stop,         // Send two stop bits.
   input  wire        low_power,        // Device is in low-power mode.
   input  wire        host_wake_req,    // Ask the host to wake up.
   output wire        wake_event,       // Pulse: activity in low power.
   output wire [15:0] baud_divisor,     // Active clocks per bit.
   output wire [1:0]  baud_source,      // Where the rate came from.
   output wire        baud_locked,      // Rate known, port running.
   input  wire        tx_valid,         // Transmit byte offered.
   output wire        tx_ready,         // Transmit byte taken.
   input  wire [7:0]  tx_data,          // Transmit byte.
   output wire        rx_valid,         // Received byte available.
   input  wire        rx_ready,         // Received byte taken.
   output wire [7:0]  rx_data,          // Received byte.
   output wire        rx_parity_error,  // Byte had a parity error.
   output wire        rx_frame_error,   // Byte had a bad stop bit.
   output wire        rx_overrun        // Pulse: byte lost, buffer full.
);

   localparam SU_SETTLE = 2'h0;
   localparam SU_AUTO   = 2'h1;
   localparam SU_RUN    = 2'h2;
   localparam LS_IDLE   = 3'h0;
   localparam LS_START  = 3'h1;
   localparam LS_DATA   = 3'h2;
   localparam LS_PAR    = 3'h3;
   localparam LS_STOP   = 3'h4;

   function [15:0] htu_div;
      input [31:0] rate;
      reg   [31:0] q;
      begin
         q = (`HTU_CLK_HZ + rate / 2) / rate;
         htu_div = q[15:0];
      end
   endfunction

   function htu_par_bit;
      input [7:0] d;
      input [1:0] mode;
      begin
         htu_par_bit = (^d) ^ (mode == `HTU_PAR_ODD);
      end
   endfunction

   reg        rx_s1_reg, rx_s2_reg, rx_prev_reg;
   reg        cts_s1_reg, cts_s2_reg, cts_prev_reg;
   reg [2:0]  strap_s1_reg, strap_s2_reg;
   reg [1:0]  su_state_reg;
   reg [1:0]  settle_reg;
   reg [15:0] div_reg;
   reg [1:0]  src_reg;
   reg        meas_reg;
   reg [15:0] meas_cnt_reg;
   reg [2:0]  rx_state_reg;
   reg [15:0] rx_cnt_reg;
   reg [2:0]  rx_bit_reg;
   reg [7:0]  rx_shift_reg;
   reg        rx_perr_reg;
   reg        rx_push_reg;
   reg        rx_ferr_reg;
   reg [9:0]  buf_mem [0:1];
   reg        wr_ptr_reg, rd_ptr_reg;
   reg [1:0]  count_reg;
   reg        overrun_reg;
   reg [2:0]  tx_state_reg;
   reg [15:0] tx_cnt_reg;
   reg [2:0]  tx_bit_reg;
   reg [7:0]  tx_shift_reg;
   reg        tx_stop2_reg;
   reg        tx_pin_reg;
   reg        rts_n_reg;
   reg        wake_reg;

   wire       run      = (su_state_reg == SU_RUN);
   wire       rx_fall  = rx_prev_reg & ~rx_s2_reg;
   wire       cts_fall = cts_prev_reg & ~cts_s2_reg;
   wire       permit   = ~(flow_enable & cts_s2_reg);
   wire       par_on   = (parity_mode != `HTU_PAR_NONE);
   wire       buf_full = (count_reg == `HTU_BUF_DEPTH);
   wire       pop      = rx_valid & rx_ready;
   wire       push     = rx_push_reg & ~buf_full;
   wire [9:0] head     = buf_mem[rd_ptr_reg];

   assign tx_pin          = tx_pin_reg;
   assign rts_n_pin       = rts_n_reg;
   assign wake_event      = wake_reg;
   assign baud_divisor    = div_reg;
   assign baud_source     = src_reg;
   assign baud_locked     = run;
   assign tx_ready        = run & ~low_power & permit &
                            (tx_state_reg == LS_IDLE);
   assign rx_valid        = (count_reg != 2'h0);
   assign rx_data         = head[7:0];
   assign rx_parity_error = head[8];
   assign rx_frame_error  = head[9];
   assign rx_overrun      = overrun_reg;

   // Pin synchronisers; logic reads the second stage and, for edge detection, its copy delayed by one cycle.
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_s1_reg    <= 1'b1;
         rx_s2_reg    <= 1'b1;
         rx_prev_reg  <= 1'b1;
         cts_s1_reg   <= 1'b0;
         cts_s2_reg   <= 1'b0;
         cts_prev_reg <= 1'b0;
         strap_s1_reg <= 3'h0;
         strap_s2_reg <= 3'h0;
      end
      else
      begin
         rx_s1_reg    <= rx_pin;
         rx_s2_reg    <= rx_s1_reg;
         rx_prev_reg  <= rx_s2_reg;
         cts_s1_reg   <= cts_n_pin;
         cts_s2_reg   <= cts_s1_reg;
         cts_prev_reg <= cts_s2_reg;
         strap_s1_reg <= {option_strap_c, option_strap_b, option_strap_a};
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // Startup: straps, then stored rate, then measured reference bit.
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         su_state_reg <= SU_SETTLE;
         settle_reg   <= 2'h0;
         div_reg      <= `HTU_DIV_RESET;
         src_reg      <= `HTU_SRC_STRAP;
         meas_reg     <= 1'b0;
         meas_cnt_reg <= 16'h0000;
      end
      else
      begin
         case (su_state_reg)
            SU_SETTLE:
            begin
               settle_reg <= settle_reg + 2'h1;
               if (settle_reg == `HTU_SETTLE)
               begin
                  su_state_reg <= SU_RUN;
                  src_reg      <= `HTU_SRC_STRAP;
                  case (strap_s2_reg)
                     3'h1: div_reg <= htu_div(`HTU_RATE_1);
                     3'h2: div_reg <= htu_div(`HTU_RATE_2);
                     3'h3: div_reg <= htu_div(`HTU_RATE_3);
                     3'h4: div_reg <= htu_div(`HTU_RATE_4);
                     3'h5: div_reg <= htu_div(`HTU_RATE_5);
                     3'h6: div_reg <= htu_div(`HTU_RATE_6);
                     3'h7: div_reg <= htu_div(`HTU_RATE_7);
                     default:
                     begin
                        if (store_valid &&
                            store_divisor >= htu_div(`HTU_RATE_MAX) &&
                            store_divisor <= htu_div(`HTU_RATE_MIN))
                        begin
                           div_reg <= store_divisor;
                           src_reg <= `HTU_SRC_STORE;
                        end
                        else
                        begin
                           su_state_reg <= SU_AUTO;
                           src_reg      <= `HTU_SRC_AUTO;
                        end
                     end
                  endcase
               end
            end
            SU_AUTO:
            begin
               // The reference start bit's low time is one bit time.
               if (rx_fall)
               begin
                  meas_reg     <= 1'b1;
                  meas_cnt_reg <= 16'h0001;
               end
               else if (meas_reg && !rx_s2_reg)
               begin
                  if (meas_cnt_reg != 16'hffff)
                     meas_cnt_reg <= meas_cnt_reg + 16'h0001;
               end
               else if (meas_reg)
               begin
                  meas_reg <= 1'b0;
                  if (meas_cnt_reg >= `HTU_AUTO_MIN)
                  begin
                     div_reg      <= meas_cnt_reg;
                     su_state_reg <= SU_RUN;
                  end
               end
            end
            default:
               su_state_reg <= SU_RUN;
         endcase
      end
   end

   // Receiver: sample each bit at its middle.
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_state_reg <= LS_IDLE;
         rx_cnt_reg   <= 16'h0000;
         rx_bit_reg   <= 3'h0;
         rx_shift_reg <= 8'h00;
         rx_perr_reg  <= 1'b0;
         rx_ferr_reg  <= 1'b0;
         rx_push_reg  <= 1'b0;
      end
      else
      begin
         rx_push_reg <= 1'b0;
         if (rx_state_reg != LS_IDLE && rx_cnt_reg != 16'h0000)
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
         else
         begin
            case (rx_state_reg)
               LS_IDLE:
                  if (run && rx_fall)
                  begin
                     rx_state_reg <= LS_START;
                     rx_cnt_reg   <= {1'b0, div_reg[15:1]};
                  end
               LS_START:
               begin
                  rx_state_reg <= rx_s2_reg ? LS_IDLE : LS_DATA;
                  rx_cnt_reg   <= div_reg - 16'h0001;
                  rx_bit_reg   <= 3'h0;
               end
               LS_DATA:
               begin
                  rx_shift_reg <= {rx_s2_reg, rx_shift_reg[7:1]};
                  rx_bit_reg   <= rx_bit_reg + 3'h1;
                  rx_cnt_reg   <= div_reg - 16'h0001;
                  if (rx_bit_reg == 3'h7)
                     rx_state_reg <= par_on ? LS_PAR : LS_STOP;
               end
               LS_PAR:
               begin
                  rx_perr_reg  <= rx_s2_reg !=
                                  htu_par_bit(rx_shift_reg, parity_mode);
                  rx_cnt_reg   <= div_reg - 16'h0001;
                  rx_state_reg <= LS_STOP;
               end
               default:
               begin
                  if (!par_on)
                     rx_perr_reg <= 1'b0;
                  rx_ferr_reg  <= ~rx_s2_reg;
                  rx_push_reg  <= 1'b1;
                  rx_state_reg <= LS_IDLE;
               end
            endcase
         end
      end
   end

   // Two-entry receive buffer; a full buffer drops the word as overrun.
   always @(posedge clock)
   begin
      if (push)
         buf_mem[wr_ptr_reg] <= {rx_ferr_reg, rx_perr_reg, rx_shift_reg};
   end

   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_ptr_reg  <= 1'b0;
         rd_ptr_reg  <= 1'b0;
         count_reg   <= 2'h0;
         overrun_reg <= 1'b0;
         rts_n_reg   <= 1'b1;
         wake_reg    <= 1'b0;
      end
      else
      begin
         overrun_reg <= rx_push_reg & buf_full;
         if (push)
            wr_ptr_reg <= ~wr_ptr_reg;
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         if (push && !pop)
            count_reg <= count_reg + 2'h1;
         else if (pop && !push)
            count_reg <= count_reg - 2'h1;
         if (low_power)
            rts_n_reg <= ~host_wake_req;
         else if (flow_enable)
            rts_n_reg <= ~run | (count_reg != 2'h0);
         else
            rts_n_reg <= 1'b0;
         wake_reg <= low_power & (rx_fall | cts_fall);
      end
   end

   // Transmitter: start bit, data LSB first, parity, stop bits.
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_state_reg <= LS_IDLE;
         tx_cnt_reg   <= 16'h0000;
         tx_bit_reg   <= 3'h0;
         tx_shift_reg <= 8'h00;
         tx_stop2_reg <= 1'b0;
         tx_pin_reg   <= 1'b1;
      end
      else if (tx_state_reg == LS_IDLE)
      begin
         tx_pin_reg <= 1'b1;
         if (tx_valid && tx_ready)
         begin
            tx_shift_reg <= tx_data;
            tx_pin_reg   <= 1'b0;
            tx_cnt_reg   <= div_reg - 16'h0001;
            tx_state_reg <= LS_START;
         end
      end
      else if (tx_cnt_reg != 16'h0000)
         tx_cnt_reg <= tx_cnt_reg - 16'h0001;
      else
      begin
         tx_cnt_reg <= div_reg - 16'h0001;
         case (tx_state_reg)
            LS_START:
            begin
               tx_pin_reg   <= tx_shift_reg[0];
               tx_bit_reg   <= 3'h0;
               tx_state_reg <= LS_DATA;
            end
            LS_DATA:
            begin
               tx_bit_reg <= tx_bit_reg + 3'h1;
               if (tx_bit_reg == 3'h7)
               begin
                  tx_stop2_reg <= two_stop;
                  if (par_on)
                  begin
                     tx_pin_reg   <= htu_par_bit(tx_shift_reg,
                                                 parity_mode);
                     tx_state_reg <= LS_PAR;
                  end
                  else
                  begin
                     tx_pin_reg   <= 1'b1;
                     tx_state_reg <= LS_STOP;
                  end
               end
               else
                  tx_pin_reg <= tx_shift_reg[tx_bit_reg + 3'h1];
            end
            LS_PAR:
            begin
               tx_pin_reg   <= 1'b1;
               tx_state_reg <= LS_STOP;
            end
            default:
            begin
               tx_pin_reg <= 1'b1;
               if (tx_stop2_reg)
                  tx_stop2_reg <= 1'b0;
               else
               begin
                  tx_cnt_reg   <= 16'h0000;
                  tx_state_reg <= LS_IDLE;
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ==== htu_uart_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module htu_uart_assertions
(
   input wire logic       clock,         // System clock.
   input wire logic       reset_n,       // Asynchronous reset, active low.
   input wire logic       tx_pin,        // Serial transmit line.
   input wire logic       rts_n_pin,     // Request to send.
   input wire logic       cts_n_pin,     // Clear to send.
   input wire logic       flow_enable,   // Handshake on.
   input wire logic       low_power,     // Low-power mode.
   input wire logic       host_wake_req, // Host wake request.
   input wire logic       wake_event,    // Wake pulse.
   input wire logic       baud_locked,   // Rate known.
   input wire logic       tx_valid,      // Transmit byte offered.
   input wire logic       tx_ready,      // Transmit byte taken.
   input wire logic       rx_valid,      // Received byte held.
   input wire logic       rx_ready,      // Received byte taken.
   input wire logic [7:0] rx_data,       // Received byte.
   input wire logic       rx_overrun     // Byte dropped.
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   AST_TX_START: assert property (
      tx_valid && tx_ready |=> (!tx_pin)[*8]) else $error("short start");
   AST_TX_BUSY: assert property (
      tx_valid && tx_ready |=> !tx_ready) else $error("ready while busy");
   AST_CTS_HOLD: assert property (
      (flow_enable && cts_n_pin)[*3] |-> !tx_ready) else $error("cts ignored");
   AST_LOCK: assert property (
      !baud_locked |-> !tx_ready) else $error("ready before lock");
   AST_LP_TX: assert property (
      low_power |-> !tx_ready) else $error("ready in low power");
   AST_HOST_WAKE: assert property (
      (low_power && host_wake_req)[*2] |-> !rts_n_pin)
      else $error("no host wake");
   AST_WAKE: assert property (
      wake_event |-> $past(low_power)) else $error("wake outside low power");
   AST_RTS_FULL: assert property (
      (flow_enable && !low_power && rx_valid)[*2] |-> rts_n_pin)
      else $error("rts low with data held");
   AST_RX_HOLD: assert property (
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("held byte changed");
   AST_OVR_PULSE: assert property (
      rx_overrun |=> !rx_overrun) else $error("overrun too long");
endmodule
bind htu_uart htu_uart_assertions i_htu_uart_assertions
(
   .clock(clock), .reset_n(reset_n), .tx_pin(tx_pin), .rts_n_pin(rts_n_pin),
   .cts_n_pin(cts_n_pin), .flow_enable(flow_enable), .low_power(low_power),
   .host_wake_req(host_wake_req), .wake_event(wake_event),
   .baud_locked(baud_locked), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
   .rx_overrun(rx_overrun)
);
`default_nettype wire

// ==== htu_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module htu_host
(
   input  wire logic clock,    // System clock.
   input  wire logic line_in,  // Device transmit line.
   output var  logic line_out, // Device receive line.
   output var  logic cts_n     // Permission to the device, active low.
);
   int         div = 22;
   logic [8:0] got[$];
   logic [8:0] w;
   initial
   begin
      line_out = 1'b1;
      cts_n    = 1'b0;
   end
   task automatic bits(input logic v, input int n);
      line_out = v;
      repeat (n * div) @(posedge clock);
      #1;
   endtask
   task automatic send(input logic [7:0] d, input logic [1:0] pm,
                       input logic bad);
      bits(1'b0, 1);
      for (int i = 0; i < 8; i++)
         bits(d[i], 1);
      if (pm != 2'h0)
         bits((pm == 2'h2 ? ^d : ~^d) ^ bad, 1);
      bits(1'b1, 2);
   endtask
   // Keeps the eight data bits and the bit after them, sampled mid-bit.
   always
   begin
      @(negedge line_in);
      repeat (div / 2) @(posedge clock);
      for (int i = 0; i < 9; i++)
      begin
         repeat (div) @(posedge clock);
         #1;
         w[i] = line_in;
      end
      got.push_back(w);
   end
endmodule
`default_nettype wire

// ==== htu_uart_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module htu_uart_test;
   logic        clock, reset_n, tx_valid, rx_ready, flow_enable, two_stop;
   logic        option_strap_a, option_strap_b, option_strap_c, store_valid;
   logic        low_power, host_wake_req, ovr_seen, wk_seen;
   logic [15:0] store_divisor;
   logic [1:0]  parity_mode;
   logic [7:0]  tx_data;
   wire         rx_pin, cts_n_pin, tx_pin, rts_n_pin, wake_event;
   wire         baud_locked, tx_ready, rx_valid, rx_overrun;
   wire         rx_parity_error, rx_frame_error;
   wire  [15:0] baud_divisor;
   wire  [1:0]  baud_source;
   wire  [7:0]  rx_data;
   int          fail_count, check_count;
   htu_uart i_htu_uart
   (
      .clock(clock), .reset_n(reset_n), .rx_pin(rx_pin), .tx_pin(tx_pin),
      .rts_n_pin(rts_n_pin), .cts_n_pin(cts_n_pin),
      .option_strap_a(option_strap_a), .option_strap_b(option_strap_b),
      .option_strap_c(option_strap_c), .store_valid(store_valid),
      .store_divisor(store_divisor), .flow_enable(flow_enable),
      .parity_mode(parity_mode), .two_stop(two_stop), .low_power(low_power),
      .host_wake_req(host_wake_req), .wake_event(wake_event),
      .baud_divisor(baud_divisor), .baud_source(baud_source),
      .baud_locked(baud_locked), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .rx_parity_error(rx_parity_error),
      .rx_frame_error(rx_frame_error), .rx_overrun(rx_overrun)
   );
   htu_host i_htu_host (.clock(clock), .line_in(tx_pin),
                        .line_out(rx_pin), .cts_n(cts_n_pin));
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock)
   begin
      if (rx_overrun === 1'b1)
         ovr_seen <= 1'b1;
      if (wake_event === 1'b1)
         wk_seen <= 1'b1;
   end
   task automatic check(input logic [23:0] seen, exp, input string m);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %0t %s: %h not %h", $time, m, seen, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic do_reset(input logic [2:0] s);
      {option_strap_c, option_strap_b, option_strap_a} = s;
      reset_n = 1'b0;
      step(4);
      check({tx_pin, rts_n_pin, rx_valid, tx_ready, baud_locked, baud_source,
             baud_divisor}, {7'h60, 16'h00ae}, "reset values");
      reset_n = 1'b1;
      step(8);
   endtask
   task automatic put_tx(input logic [7:0] d);
      int n;
      n = 0;
      tx_data = d;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && n < 600)
      begin
         step(1);
         n++;
      end
      step(1);
      tx_valid = 1'b0;
      step(1);
   endtask
   task automatic get_tx(input logic [8:0] exp);
      int n;
      n = 0;
      while (i_htu_host.got.size() == 0 && n < 600)
      begin
         step(1);
         n++;
      end
      check(i_htu_host.got.size() ? i_htu_host.got.pop_front() : 'x, exp,
            "tx char");
   endtask
   task automatic get_rx(input logic [7:0] d, input logic pe);
      int n;
      n = 0;
      while (rx_valid !== 1'b1 && n < 600)
      begin
         step(1);
         n++;
      end
      check({rx_data, rx_parity_error, rx_frame_error}, {d, pe, 1'b0},
            "rx char");
      rx_ready = 1'b1;
      step(1);
      rx_ready = 1'b0;
      step(1);
   endtask
   task automatic t_start;
      do_reset(3'h7);
      check({baud_locked, baud_source, baud_divisor}, {3'h4, 16'h0016},
            "strap rate");
      store_valid = 1'b1;
      store_divisor = 16'h0064;
      do_reset(3'h0);
      check({baud_locked, baud_source, baud_divisor}, {3'h5, 16'h0064},
            "stored rate");
      store_divisor = 16'h0005;
      do_reset(3'h0);
      check({baud_locked, baud_source}, 3'h2, "auto wait");
      i_htu_host.send(8'h55, 2'h0, 1'b0);
      check({baud_locked, baud_source, baud_divisor}, {3'h6, 16'h0016},
            "auto rate");
      do_reset(3'h7);
      $display("t_start done");
   endtask
   task automatic t_tx;
      logic [7:0] d;
      two_stop = 1'b1;
      for (int m = 0; m < 3; m++)
      begin
         parity_mode = m[1:0];
         d = 8'ha5 ^ m[7:0];
         put_tx(d);
         get_tx({m == 0 ? 1'b1 : (m == 1 ? ~^d : ^d), d});
      end
      put_tx(8'h01);
      put_tx(8'h80);
      get_tx({1'b1, 8'h01});
      get_tx({1'b1, 8'h80});
      two_stop = 1'b0;
      $display("t_tx done");
   endtask
   task automatic t_rx;
      for (int m = 0; m < 3; m++)
      begin
         parity_mode = m[1:0];
         i_htu_host.send(8'h5a ^ m[7:0], m[1:0], 1'b0);
         get_rx(8'h5a ^ m[7:0], 1'b0);
      end
      i_htu_host.send(8'hc3, 2'h2, 1'b1);
      get_rx(8'hc3, 1'b1);
      parity_mode = 2'h0;
      i_htu_host.bits(1'b0, 1);
      i_htu_host.bits(1'b1, 8);
      i_htu_host.bits(1'b0, 1);
      i_htu_host.bits(1'b1, 2);
      check({rx_valid, rx_data, rx_parity_error, rx_frame_error},
            {1'b1, 8'hff, 2'h1}, "frame error");
      rx_ready = 1'b1;
      step(1);
      rx_ready = 1'b0;
      step(1);
      $display("t_rx done");
   endtask
   task automatic t_cts;
      put_tx(8'h3c);
      i_htu_host.cts_n = 1'b1;
      get_tx({1'b1, 8'h3c});
      tx_data = 8'h77;
      tx_valid = 1'b1;
      step(30);
      check({tx_ready, tx_pin}, 2'h1, "held by cts");
      flow_enable = 1'b0;
      put_tx(8'h77);
      get_tx({1'b1, 8'h77});
      flow_enable = 1'b1;
      i_htu_host.cts_n = 1'b0;
      $display("t_cts done");
   endtask
   task automatic t_buf;
      i_htu_host.send(8'h11, 2'h0, 1'b0);
      step(4);
      check(rts_n_pin, 1'b1, "rts on data");
      i_htu_host.send(8'h22, 2'h0, 1'b0);
      i_htu_host.send(8'h33, 2'h0, 1'b0);
      step(4);
      check(ovr_seen, 1'b1, "overrun");
      get_rx(8'h11, 1'b0);
      get_rx(8'h22, 1'b0);
      step(4);
      check({rx_valid, rts_n_pin}, 2'h0, "drained");
      $display("t_buf done");
   endtask
   task automatic t_lp;
      low_power = 1'b1;
      host_wake_req = 1'b1;
      step(3);
      check({rts_n_pin, tx_ready, wk_seen}, 3'h0, "host wake");
      host_wake_req = 1'b0;
      i_htu_host.cts_n = 1'b1;
      step(4);
      i_htu_host.cts_n = 1'b0;
      step(5);
      check({rts_n_pin, wk_seen}, 2'h3, "device wake");
      low_power = 1'b0;
      $display("t_lp done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #3000000;
      fail_count++;
      $display("BAD %0t timeout", $time);
      conclude;
   end
   initial
   begin
      {tx_valid, rx_ready, two_stop, low_power, host_wake_req} = 5'h00;
      {ovr_seen, wk_seen, store_valid, flow_enable} = 4'h1;
      {tx_data, store_divisor, parity_mode} = 26'h0;
      t_start;
      t_tx;
      t_rx;
      t_cts;
      t_buf;
      t_lp;
      conclude;
   end
endmodule
`default_nettype wire
